//--- bench/utxb_core_bench.sv
// Self-checking bench for the serial port buffer block
`timescale 1ns/1ns
module utxb_core_bench;
	localparam int DIV = 4;
	logic sys_clk = 0, rst_b = 0, dataWrite = 0, dataRead = 0, txNinthBit = 0, txEnable = 1;
	logic rxEnable = 1, parityEnable = 0, parityOdd = 0, twoStopBits = 0, syncMode = 0;
	logic txDoneIrqAck = 0, txDoneClearWrite = 0, txEmptyIrqEn = 1, txDoneIrqEn = 1;
	logic extXferClock;
	logic [7:0] dataWriteValue = 8'h00;
	logic [2:0] charSize = 3'h3;
	logic serialIn, serialOut, serialOutEn, rxPinOwned, txBufferEmptyFlag, txDoneFlag;
	logic txEmptyIrq, txDoneIrq, rxReadyFlag, rxNinthBit, frameErrFlag, overrunFlag;
	logic parityErrFlag;
	logic [7:0] rxData;
	int badCount = 0, checks = 0;
	always #5 sys_clk = ~sys_clk;
	utxb_core #(.BAUD_DIV(DIV)) utxb_core_i (.sys_clk, .rst_b, .dataWrite, .dataWriteValue,
		.dataRead, .txNinthBit, .txEnable, .rxEnable, .parityEnable, .parityOdd, .twoStopBits,
		.charSize, .syncMode, .txDoneIrqAck, .txDoneClearWrite, .txEmptyIrqEn, .txDoneIrqEn,
		.extXferClock, .serialIn, .serialOut, .serialOutEn, .rxPinOwned, .txBufferEmptyFlag,
		.txDoneFlag, .txEmptyIrq, .txDoneIrq, .rxReadyFlag, .rxData, .rxNinthBit,
		.frameErrFlag, .overrunFlag, .parityErrFlag);
	utxb_node #(.DIV(DIV)) utxb_node_i (.sys_clk, .serialOut, .serialOutEn, .bits(4'h8),
		.withPar(parityEnable), .serialIn, .extXferClock);
	function automatic logic [11:0] seenFrame;
		seenFrame = {2'h0, utxb_node_i.stopBit, utxb_node_i.parBit, utxb_node_i.data[7:0]};
	endfunction
	task tick;
		@(posedge sys_clk);
		#1;
	endtask
	task stopTest;
		$display("checks %0d mismatches %0d", checks, badCount);
		if (badCount == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task chk(input string what, input logic [11:0] exp, input logic [11:0] got);
		checks++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", what, exp, got);
			badCount++;
		end
	endtask
	task waitOn(input int k);
		int n;
		n = 0;
		while ((k == 0 ? txDoneFlag : (k == 1 ? rxReadyFlag : txBufferEmptyFlag)) !== 1'b1) begin
			tick;
			n++;
			if (n > 400) begin
				badCount++;
				stopTest;
			end
		end
	endtask
	task writeByte(input logic [7:0] d);
		txNinthBit = 1'b0;
		dataWriteValue = d;
		dataWrite = 1'b1;
		tick;
		dataWrite = 1'b0;
	endtask
	task clearDone(input logic viaAck);
		if (viaAck) txDoneIrqAck = 1'b1;
		else txDoneClearWrite = 1'b1;
		tick;
		txDoneIrqAck = 1'b0;
		txDoneClearWrite = 1'b0;
		chk("done flag", 12'h000, {11'h0, txDoneFlag});
	endtask
	task tTx(input logic [7:0] d, input logic odd);
		parityEnable = 1'b1;
		parityOdd = odd;
		twoStopBits = odd;
		writeByte(d);
		chk("empty flag", 12'h000, {11'h0, txBufferEmptyFlag});
		waitOn(0);
		chk("frame", {3'h1, odd ^ (^d), d}, seenFrame());
		chk("requests", 12'h003, {10'h0, txEmptyIrq, txDoneIrq});
		clearDone(odd);
	endtask
	task tDisable;
		writeByte(8'h5A);
		txEnable = 1'b0;
		repeat (DIV * 3) tick;
		chk("pin held", 12'h001, {11'h0, serialOutEn});
		waitOn(0);
		repeat (3) tick;
		chk("pin released", 12'h001, {10'h0, serialOutEn, serialOut});
		writeByte(8'h11);
		tick;
		chk("ignored write", 12'h001, {11'h0, txBufferEmptyFlag});
		txEnable = 1'b1;
		clearDone(1'b1);
	endtask
	task tBack;
		writeByte(8'h81);
		waitOn(2);
		writeByte(8'h42);
		waitOn(2);
		chk("done early", 12'h000, {11'h0, txDoneFlag});
		waitOn(0);
		chk("second frame", 12'h342, seenFrame());
		txEmptyIrqEn = 1'b0;
		tick;
		chk("masked request", 12'h001, {10'h0, txEmptyIrq, txDoneIrq});
		txEmptyIrqEn = 1'b1;
		clearDone(1'b0);
	endtask
	task tSync;
		parityEnable = 1'b0;
		charSize = 3'h3;
		syncMode = 1'b1;
		utxb_node_i.sendSync(8'hC5);
		rxRead(12'h0C5);
		syncMode = 1'b0;
	endtask
	task rxRead(input logic [11:0] exp);
		waitOn(1);
		chk("rx entry", exp, {rxNinthBit, frameErrFlag, overrunFlag, parityErrFlag,
			rxData});
		dataRead = 1'b1;
		tick;
		dataRead = 1'b0;
		repeat (2) tick;
	endtask
	task tRx;
		parityEnable = 1'b0;
		charSize = 3'h2;
		utxb_node_i.send(9'h1FF, 4'h7, 1'b0, 1'b0, 1'b1);
		rxRead(12'h07F);
		charSize = 3'h7;
		parityEnable = 1'b1;
		parityOdd = 1'b0;
		utxb_node_i.send(9'h155, 4'h9, 1'b1, 1'b1, 1'b1);
		utxb_node_i.send(9'h0F0, 4'h9, 1'b1, 1'b1, 1'b0);
		utxb_node_i.send(9'h1C3, 4'h9, 1'b1, 1'b1, 1'b1);
		utxb_node_i.send(9'h03C, 4'h9, 1'b1, 1'b0, 1'b1);
		rxRead(12'h855);
		rxRead(12'h5F0);
		rxRead(12'h23C);
		utxb_node_i.send(9'h021, 4'h9, 1'b1, 1'b0, 1'b1);
		waitOn(1);
		rxEnable = 1'b0;
		repeat (2) tick;
		chk("ready flushed", 12'h000, {11'h0, rxReadyFlag});
		rxEnable = 1'b1;
	endtask
	initial begin
		repeat (16) tick;
		rst_b = 1'b1;
		tick;
		tTx(8'hA5, 1'b0);
		tTx(8'h3C, 1'b1);
		tDisable;
		tBack;
		tRx;
		tSync;
		stopTest;
	end
	initial begin
		repeat (20000) tick;
		badCount++;
		stopTest;
	end
endmodule

//--- bench/utxb_core_properties.sv
// Checker for transmit flags and receive buffer outputs
`timescale 1ns/1ns
module utxb_core_properties (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic dataWrite,
	input wire logic dataRead,
	input wire logic txEnable,
	input wire logic rxEnable,
	input wire logic txDoneIrqAck,
	input wire logic txDoneClearWrite,
	input wire logic txEmptyIrqEn,
	input wire logic txDoneIrqEn,
	input wire logic serialOut,
	input wire logic serialOutEn,
	input wire logic rxPinOwned,
	input wire logic txBufferEmptyFlag,
	input wire logic txDoneFlag,
	input wire logic txEmptyIrq,
	input wire logic txDoneIrq,
	input wire logic rxReadyFlag
);
	logic writeSeen;
	default clocking cb @(posedge sys_clk); endclocking
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			writeSeen <= 1'b0;
		end else begin
			writeSeen <= (dataWrite && (txEnable || serialOutEn)) || (txDoneFlag && writeSeen);
		end
	end
	default disable iff (!rst_b);
	sequence s_load;
		dataWrite && (txEnable || serialOutEn);
	endsequence
	sequence s_pending;
		serialOutEn && !txBufferEmptyFlag;
	endsequence
	a_write_clears_empty: assert property (s_load |=> !txBufferEmptyFlag)
		else $error("empty flag kept after write");
	a_empty_irq_level: assert property (txEmptyIrq == (txBufferEmptyFlag && txEmptyIrqEn))
		else $error("empty request wrong");
	a_done_needs_empty: assert property ($rose(txDoneFlag) |-> $past(txBufferEmptyFlag))
		else $error("done set with full buffer");
	a_done_clear_pulse: assert property (txDoneFlag && !writeSeen &&
		(txDoneIrqAck || txDoneClearWrite) |=> !txDoneFlag)
		else $error("done flag not cleared");
	a_done_irq_level: assert property (txDoneIrq == (txDoneFlag && txDoneIrqEn))
		else $error("done request wrong");
	a_disable_waits: assert property (s_pending |=> serialOutEn)
		else $error("pin released with pending char");
	a_idle_line_high: assert property (!serialOutEn |-> serialOut)
		else $error("released line not high");
	a_rx_pin_owned: assert property (rxPinOwned == rxEnable)
		else $error("input pin ownership wrong");
	a_rx_flush: assert property (!rxEnable |=> !rxReadyFlag)
		else $error("ready flag survived disable");
	a_ready_fall_cause: assert property ($fell(rxReadyFlag) |->
		$past(dataRead) || !$past(rxEnable) || !rxEnable)
		else $error("ready fell without read");
endmodule
bind utxb_core utxb_core_properties utxb_core_properties_i (.sys_clk, .rst_b, .dataWrite,
	.dataRead, .txEnable, .rxEnable, .txDoneIrqAck, .txDoneClearWrite, .txEmptyIrqEn,
	.txDoneIrqEn, .serialOut, .serialOutEn, .rxPinOwned, .txBufferEmptyFlag, .txDoneFlag,
	.txEmptyIrq, .txDoneIrq, .rxReadyFlag);

//--- bench/utxb_node.sv
// Remote serial node model on the line side
`timescale 1ns/1ns
module utxb_node #(
	parameter int DIV = 4
) (
	input wire logic sys_clk,
	input wire logic serialOut,
	input wire logic serialOutEn,
	input wire logic [3:0] bits,
	input wire logic withPar,
	output logic serialIn,
	output logic extXferClock
);
	logic [8:0] data;
	logic parBit;
	logic stopBit;
	initial serialIn = 1'b1;
	initial extXferClock = 1'b0;
	task bitOut(input logic b);
		serialIn = b;
		repeat (DIV) @(posedge sys_clk);
		#1;
	endtask
	task send(input logic [8:0] d, input logic [3:0] n, input logic pOn, input logic p,
		input logic st);
		bitOut(1'b0);
		for (int i = 0; i < n; i++) bitOut(d[i]);
		if (pOn) bitOut(p);
		bitOut(st);
		bitOut(1'b1);
	endtask
	task sendSync(input logic [7:0] d);
		for (int i = 0; i < 10; i++) begin
			serialIn = (i == 0) ? 1'b0 : ((i == 9) ? 1'b1 : d[i - 1]);
			repeat (DIV) @(posedge sys_clk);
			#1;
			extXferClock = 1'b1;
			repeat (DIV) @(posedge sys_clk);
			#1;
			extXferClock = 1'b0;
		end
		serialIn = 1'b1;
	endtask
	always begin
		@(negedge serialOut iff serialOutEn);
		repeat (DIV / 2) @(posedge sys_clk);
		data = 9'h000;
		for (int i = 0; i < bits; i++) begin
			repeat (DIV) @(posedge sys_clk);
			data[i] = serialOut;
		end
		if (withPar) begin
			repeat (DIV) @(posedge sys_clk);
			parBit = serialOut;
		end
		repeat (DIV) @(posedge sys_clk);
		stopBit = serialOut;
	end
endmodule

//--- logic/utxb_core.sv
// Serial port transmit and receive buffer logic with receive FIFO
// Summary of operation
// - Buffer-empty flag high when transmit buffer empty, low while holding a character.
// - Writing the data port clears the buffer-empty flag while transmit is enabled or the transmitter still owns the pin.
// - Buffer-empty interrupt is a level while flag set and enabled.
// - Done flag sets when frame shifted out and transmit buffer empty.
// - Done flag clears on interrupt service or on writing one.
// - Done interrupt raised as done flag sets, when enabled.
// - With parity enabled, parity bit goes after last data bit, before stop.
// - Transmit disable waits until shift register and buffer are empty.
// - When disabled, the transmitter stops driving the serial output pin.
// - Receive enable hands the serial input pin to the receiver.
// - In synchronous mode the external transfer clock times the bits.
// - Frame begins on a valid start bit; bits sampled until first stop.
// - Any second stop bit is ignored.
// - On first stop bit the frame moves into the receive buffer.
// - Unused upper data bits read as zero.
// - Ninth bit and error flags travel in the FIFO; reads advance it.
// - Ready flag shows unread data; receiver disable flushes buffer.
// - Parity is xor of data bits, inverted for odd parity.
// - Two-character buffer; overrun on full buffer, waiting frame, new start.
`timescale 1ns/1ns
`include "utxb_params.svh"

module utxb_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic flush,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr;
	logic [AW-1:0] rdPtr;
	logic [AW:0] count;
	logic push;
	logic pop;

	function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
		nextPtr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign inReady = (count != (AW+1)'(DEPTH));
	assign outValid = (count != '0);
	assign outData = mem[rdPtr];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wrPtr] <= inData;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else if (flush) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wrPtr <= nextPtr(wrPtr);
			end
			if (pop) begin
				rdPtr <= nextPtr(rdPtr);
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule

module utxb_core #(
	parameter int BAUD_DIV = `UTXB_BAUD_DIV,
	parameter int RX_DEPTH = `UTXB_RX_DEPTH
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic dataWrite,
	input wire logic [7:0] dataWriteValue,
	input wire logic dataRead,
	input wire logic txNinthBit,
	input wire logic txEnable,
	input wire logic rxEnable,
	input wire logic parityEnable,
	input wire logic parityOdd,
	input wire logic twoStopBits,
	input wire logic [2:0] charSize,
	input wire logic syncMode,
	input wire logic txDoneIrqAck,
	input wire logic txDoneClearWrite,
	input wire logic txEmptyIrqEn,
	input wire logic txDoneIrqEn,
	input wire logic extXferClock,
	input wire logic serialIn,
	output logic serialOut,
	output logic serialOutEn,
	output logic rxPinOwned,
	output logic txBufferEmptyFlag,
	output logic txDoneFlag,
	output logic txEmptyIrq,
	output logic txDoneIrq,
	output logic rxReadyFlag,
	output logic [7:0] rxData,
	output logic rxNinthBit,
	output logic frameErrFlag,
	output logic overrunFlag,
	output logic parityErrFlag
);
	localparam int HALF = BAUD_DIV / 2;
	logic [15:0] baudCnt;
	logic [15:0] rxCnt;
	logic [2:0] extSync;
	logic [1:0] inSync;
	logic rxIn;
	logic extRise;
	logic extFall;
	logic txTick;
	logic rxSample;
	logic [7:0] txBuf;
	logic txBufNinth;
	logic txBufFull;
	logic txActive;
	logic [8:0] txShift;
	logic [3:0] txIdx;
	logic [1:0] txStopCnt;
	logic txLoad;
	logic txLastStop;
	utxb_pkg::utxb_tx_e txState;
	utxb_pkg::utxb_rx_e rxState;
	logic [8:0] rxShift;
	logic [3:0] rxIdx;
	logic rxParBit;
	logic [`UTXB_ENTRY_W-1:0] rxHeld;
	logic rxHeldValid;
	logic fifoInReady;
	logic fifoOutValid;
	logic [`UTXB_ENTRY_W-1:0] fifoOut;
	logic dorPending;
	logic startSeen;

	function automatic logic [3:0] dataBits(input logic [2:0] size);
		dataBits = (size == `UTXB_CHAR9) ? 4'h9 : 4'(5 + size[1:0]);
	endfunction

	function automatic logic calcParity(input logic [8:0] d, input logic [3:0] n,
			input logic odd);
		logic p;
		p = odd;
		for (int i = 0; i < 9; i++) begin
			if (4'(i) < n) begin
				p = p ^ d[i];
			end
		end
		calcParity = p;
	endfunction

	// Pin synchronisers
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			extSync <= '0;
			inSync <= 2'h3;
		end else begin
			extSync <= {extSync[1:0], extXferClock};
			inSync <= {inSync[0], serialIn};
		end
	end

	assign rxIn = inSync[1];
	assign extRise = extSync[1] && !extSync[2];
	assign extFall = !extSync[1] && extSync[2];

	// Bit rate divider
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			baudCnt <= '0;
		end else begin
			baudCnt <= (baudCnt == 16'(BAUD_DIV - 1)) ? '0 : baudCnt + 1'b1;
		end
	end

	assign txTick = syncMode ? extFall : (baudCnt == 16'(BAUD_DIV - 1));

	// Transmit buffer
	assign txLastStop = txTick && (txState == utxb_pkg::TX_STOP) &&
		(txStopCnt == (twoStopBits ? 2'h2 : 2'h1));
	assign txLoad = txBufFull && txActive &&
		((txState == utxb_pkg::TX_IDLE) || txLastStop);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			txBuf <= '0;
			txBufNinth <= 1'b0;
			txBufFull <= 1'b0;
		end else if (dataWrite && (txEnable || txActive)) begin
			txBuf <= dataWriteValue;
			txBufNinth <= txNinthBit;
			txBufFull <= 1'b1;
		end else if (txLoad) begin
			txBufFull <= 1'b0;
		end
	end

	assign txBufferEmptyFlag = !txBufFull;
	assign txEmptyIrq = txEmptyIrqEn && !txBufFull;

	// Transmitter ownership of the output pin
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			txActive <= 1'b0;
		end else if (txEnable) begin
			txActive <= 1'b1;
		end else if (!txBufFull && !dataWrite && txState == utxb_pkg::TX_IDLE) begin
			txActive <= 1'b0;
		end
	end

	// Transmit shifter
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			txState <= utxb_pkg::TX_IDLE;
			txShift <= '0;
			txIdx <= '0;
			txStopCnt <= '0;
			serialOut <= 1'b1;
		end else if (txLoad) begin
			txState <= txLastStop ? utxb_pkg::TX_DATA : utxb_pkg::TX_START;
			txShift <= {txBufNinth, txBuf};
			txIdx <= '0;
			txStopCnt <= '0;
			if (txLastStop) begin
				serialOut <= 1'b0;
			end
		end else if (txTick) begin
			case (txState)
				utxb_pkg::TX_IDLE: begin
					serialOut <= 1'b1;
				end
				utxb_pkg::TX_START: begin
					serialOut <= 1'b0;
					txState <= utxb_pkg::TX_DATA;
				end
				utxb_pkg::TX_DATA: begin
					serialOut <= txShift[txIdx];
					txIdx <= txIdx + 1'b1;
					if (txIdx == dataBits(charSize) - 1'b1) begin
						txState <= parityEnable ? utxb_pkg::TX_PAR : utxb_pkg::TX_STOP;
					end
				end
				utxb_pkg::TX_PAR: begin
					serialOut <= calcParity(txShift, dataBits(charSize), parityOdd);
					txState <= utxb_pkg::TX_STOP;
				end
				utxb_pkg::TX_STOP: begin
					serialOut <= 1'b1;
					txStopCnt <= txStopCnt + 1'b1;
					if (txLastStop) begin
						txState <= utxb_pkg::TX_IDLE;
					end
				end
				default: begin
					txState <= utxb_pkg::TX_IDLE;
				end
			endcase
		end
	end

	assign serialOutEn = txActive;

	// Transmit done flag, set wins over clear
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			txDoneFlag <= 1'b0;
		end else if (txLastStop && !txBufFull) begin
			txDoneFlag <= 1'b1;
		end else if (txDoneIrqAck || txDoneClearWrite) begin
			txDoneFlag <= 1'b0;
		end
	end

	assign txDoneIrq = txDoneIrqEn && txDoneFlag;
	assign rxPinOwned = rxEnable;

	// Receive timing
	assign rxSample = syncMode ? extRise :
		(rxCnt == ((rxState == utxb_pkg::RX_START) ? 16'(HALF) : 16'(BAUD_DIV - 1)));
	assign startSeen = rxEnable && (rxState == utxb_pkg::RX_IDLE) && !rxIn &&
		(!syncMode || extRise);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rxCnt <= '0;
		end else if (rxSample || rxState == utxb_pkg::RX_IDLE) begin
			rxCnt <= '0;
		end else begin
			rxCnt <= rxCnt + 1'b1;
		end
	end

	// Receive shifter
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rxState <= utxb_pkg::RX_IDLE;
			rxShift <= '0;
			rxIdx <= '0;
			rxParBit <= 1'b0;
		end else if (!rxEnable) begin
			rxState <= utxb_pkg::RX_IDLE;
		end else begin
			case (rxState)
				utxb_pkg::RX_IDLE: begin
					if (startSeen) begin
						rxShift <= '0;
						rxIdx <= '0;
						rxState <= syncMode ? utxb_pkg::RX_DATA : utxb_pkg::RX_START;
					end
				end
				utxb_pkg::RX_START: begin
					if (rxSample) begin
						rxState <= rxIn ? utxb_pkg::RX_IDLE : utxb_pkg::RX_DATA;
					end
				end
				utxb_pkg::RX_DATA: begin
					if (rxSample) begin
						rxShift[rxIdx] <= rxIn;
						rxIdx <= rxIdx + 1'b1;
						if (rxIdx == dataBits(charSize) - 1'b1) begin
							rxState <= parityEnable ? utxb_pkg::RX_PAR : utxb_pkg::RX_STOP;
						end
					end
				end
				utxb_pkg::RX_PAR: begin
					if (rxSample) begin
						rxParBit <= rxIn;
						rxState <= utxb_pkg::RX_STOP;
					end
				end
				utxb_pkg::RX_STOP: begin
					if (rxSample) begin
						rxState <= utxb_pkg::RX_IDLE;
					end
				end
				default: begin
					rxState <= utxb_pkg::RX_IDLE;
				end
			endcase
		end
	end

	// Completed frame waiting for the buffer
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rxHeld <= '0;
			rxHeldValid <= 1'b0;
		end else if (!rxEnable) begin
			rxHeldValid <= 1'b0;
		end else if (rxState == utxb_pkg::RX_STOP && rxSample) begin
			rxHeldValid <= 1'b1;
			rxHeld[7:0] <= rxShift[7:0];
			rxHeld[`UTXB_POS_NINTH] <= (charSize == `UTXB_CHAR9) && rxShift[8];
			rxHeld[`UTXB_POS_FE] <= !rxIn;
			rxHeld[`UTXB_POS_DOR] <= dorPending || (rxHeldValid && !fifoInReady);
			rxHeld[`UTXB_POS_PE] <= parityEnable &&
				(calcParity(rxShift, dataBits(charSize), parityOdd) != rxParBit);
		end else if (fifoInReady) begin
			rxHeldValid <= 1'b0;
		end
	end

	// Overrun pending until a frame reaches the buffer, set wins
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			dorPending <= 1'b0;
		end else if (!rxEnable) begin
			dorPending <= 1'b0;
		end else if (startSeen && rxHeldValid && !fifoInReady) begin
			dorPending <= 1'b1;
		end else if (rxState == utxb_pkg::RX_STOP && rxSample) begin
			dorPending <= 1'b0;
		end
	end

	utxb_fifo #(
		.WIDTH(`UTXB_ENTRY_W),
		.DEPTH(RX_DEPTH)
	) rxFifo (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.flush(!rxEnable),
		.inValid(rxHeldValid),
		.inReady(fifoInReady),
		.inData(rxHeld),
		.outValid(fifoOutValid),
		.outReady(dataRead),
		.outData(fifoOut)
	);

	assign rxReadyFlag = fifoOutValid;
	assign rxData = fifoOutValid ? fifoOut[7:0] : 8'h00;
	assign rxNinthBit = fifoOutValid && fifoOut[`UTXB_POS_NINTH];
	assign frameErrFlag = fifoOutValid && fifoOut[`UTXB_POS_FE];
	assign overrunFlag = fifoOutValid && fifoOut[`UTXB_POS_DOR];
	assign parityErrFlag = fifoOutValid && fifoOut[`UTXB_POS_PE];
endmodule

//--- shared/utxb_params.svh
// Constants for the serial port buffer block
`ifndef UTXB_PARAMS_SVH
`define UTXB_PARAMS_SVH
`define UTXB_BAUD_DIV 16
`define UTXB_RX_DEPTH 2
`define UTXB_CHAR9 3'h7
`define UTXB_ENTRY_W 12
`define UTXB_POS_NINTH 11
`define UTXB_POS_FE 10
`define UTXB_POS_DOR 9
`define UTXB_POS_PE 8
`endif

//--- shared/utxb_pkg.sv
// Types for the serial port buffer block
package utxb_pkg;
	typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} utxb_tx_e;
	typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} utxb_rx_e;
endpackage
